/* File: rtl/qspd_div.v */
// One quarter-step divider: four output pulses per divide number of ticks, two when i_range is low
`timescale 1ns/10ps
`include "qspd_map.vh"

module qspd_div
#(
  parameter DIV_W = 6
)
(
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Control
  input  wire             i_run,
  input  wire             i_tick,
  input  wire [DIV_W-1:0] i_divide,
  input  wire             i_range,
  // Result
  output reg              o_out,
  output reg              o_pulse
);

  localparam CNT_W = DIV_W - 2;

  reg [CNT_W-1:0] cnt;
  reg             cc;
  reg             load_mode;
  reg [1:0]       seq;
  reg             half;
  reg             incr;
  reg [1:0]       next_seq;
  wire            divide_lsb0;
  wire            divide_lsb1;
  wire [CNT_W-1:0] eoc_point;
  wire            eoc;

  assign divide_lsb0 = i_divide[`QSPD_DIV_LSB0];
  assign divide_lsb1 = i_divide[`QSPD_DIV_LSB1];

  // Increment decoder: chosen only by the two low divide bits
  always @*
  begin
    case (seq)
      `QSPD_SEQ_S1: incr = 1'b0;
      `QSPD_SEQ_S2: incr = divide_lsb1;
      `QSPD_SEQ_S3: incr = divide_lsb0;
      `QSPD_SEQ_S4: incr = divide_lsb1;
      default:      incr = 1'b0;
    endcase
  end

  // Sequencer order LL, HH, LH, HL
  always @*
  begin
    case (seq)
      `QSPD_SEQ_S1: next_seq = `QSPD_SEQ_S2;
      `QSPD_SEQ_S2: next_seq = `QSPD_SEQ_S3;
      `QSPD_SEQ_S3: next_seq = `QSPD_SEQ_S4;
      `QSPD_SEQ_S4: next_seq = `QSPD_SEQ_S1;
      default:      next_seq = `QSPD_SEQ_S1;
    endcase
  end

  // End of count at 0010, or 0001 for an incremented cycle
  assign eoc_point = incr ? `QSPD_EOC_INC : `QSPD_EOC_BASE;
  // Decoder is inhibited while count control is set
  assign eoc = ~cc & ~load_mode & (cnt == eoc_point);

  // Counter, count control, output and sequencer flip-flops
  always @(posedge i_clk)
  begin
    if (!i_rst_n || !i_run)
    begin
      cnt       <= {CNT_W{1'b0}};
      cc        <= 1'b0;
      o_out     <= 1'b0;
      o_pulse   <= 1'b0;
      seq       <= `QSPD_SEQ_S1;
      half      <= 1'b0;
      load_mode <= 1'b1;
    end
    else
    begin
      o_pulse <= 1'b0;
      if (i_tick)
      begin
        if (cc || load_mode)
        begin
          // Reset flip-flops and reload for the next countdown
          cnt       <= i_divide[DIV_W-1:2];
          cc        <= 1'b0;
          o_out     <= 1'b0;
          load_mode <= 1'b0;
          if (cc)
            seq <= next_seq;
        end
        else
        begin
          cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
          if (eoc)
          begin
            cc   <= 1'b1;
            half <= ~half;
            // Small numbers pass only every second end of count
            if (i_range || half)
            begin
              o_out   <= 1'b1;
              o_pulse <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule // qspd_div

/* File: rtl/qspd_map.vh */
// Constants for the quarter-step programmable divider pair
`ifndef QSPD_MAP_VH
`define QSPD_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define QSPD_ADDR_CTRL      8'h00
`define QSPD_ADDR_NDIV      8'h04
`define QSPD_ADDR_MDIV      8'h08
`define QSPD_ADDR_STATUS    8'h0c
`define QSPD_ADDR_IRQ_STAT  8'h10
`define QSPD_ADDR_IRQ_CLR   8'h14
`define QSPD_ADDR_IRQ_EN    8'h18
`define QSPD_ADDR_LOCK_WIN  8'h1c

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define QSPD_RST_CTRL       1'h0
`define QSPD_RST_DIV        6'h10
`define QSPD_RST_IRQ        3'h0
`define QSPD_RST_LOCK_WIN   8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define QSPD_CTRL_RUN       0
`define QSPD_EV_NDIV        0
`define QSPD_EV_MDIV        1
`define QSPD_EV_UNLOCK      2
`define QSPD_DIV_LSB0       0
`define QSPD_DIV_LSB1       1
`define QSPD_RANGE_LO       4
`define QSPD_RANGE_HI       5

// ----------------------------------------------------------------------
// Countdown end points and sequencer codes
// ----------------------------------------------------------------------
`define QSPD_EOC_BASE       4'h2
`define QSPD_EOC_INC        4'h1
`define QSPD_SEQ_S1         2'h0
`define QSPD_SEQ_S2         2'h3
`define QSPD_SEQ_S3         2'h1
`define QSPD_SEQ_S4         2'h2

`endif

/* File: rtl/qspd_top.v */
// Divider pair with phase detector, lock detector and APB registers
//
// What this block does
// - Count control set inhibits end decoder, loads counter, clocks output.
// - Output flip-flop set drives a high divider output pulse.
// - Next tick after a pulse clears flip-flops and reloads the counter.
// - Four load-and-countdown cycles form one divide sequence.
// - Increment decoder uses only the two low divide bits.
// - Four-state sequencer picks quarter or quarter plus one per cycle.
// - Low bits both zero: every cycle uses the plain quarter count.
// - Low bits both one: decoder low first state, high other three.
// - Incremented cycle counts down to 0001 instead of 0010.
// - Cycle loads upper divide bits, decrements, ends at 0010.
// - Reference divide number sixteen or more passes every end of count.
// - Reference divide number below sixteen sets output every second time.
// - Second divider identical, fed by the same range bits.
// - Detector pulses output of leading divider, width equals difference.
// - Lock detector flags unlocked when pulse exceeds allowed window.
// - Output rate equals reference rate over a quarter divide number from sixteen up.
// - Sequencer walks LL, HH, LH, HL and repeats.
`timescale 1ns/10ps
`include "qspd_map.vh"

module qspd_top
#(
  parameter DIV_W = 6,
  parameter WIN_W = 8
)
(
  // Clock and reset
  input  wire        I_CLK,
  input  wire        I_RST_N,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  // Divider input ticks
  input  wire        I_REF_TICK,
  input  wire        I_IF_TICK,
  // Divider and detector outputs
  output reg         O_N_DIV,
  output reg         O_M_DIV,
  output reg         O_DETECTOR_OUT_A,
  output reg         O_DETECTOR_OUT_B,
  output reg         O_UNLOCKED,
  // Interrupt
  output reg         O_IRQ
);

  // --------------------------------------------------------------------
  // Registers and wires
  // --------------------------------------------------------------------
  reg              run;
  reg [DIV_W-1:0]  ndiv;
  reg [DIV_W-1:0]  mdiv;
  reg [2:0]        irq_stat;
  reg [2:0]        irq_en;
  reg [WIN_W-1:0]  lock_win;
  reg [WIN_W-1:0]  width;
  reg              n_prev;
  reg              m_prev;
  reg              next_a;
  reg              next_b;
  reg [31:0]       rd_val;
  reg              rd_ok;
  wire             n_out;
  wire             m_out;
  wire             n_pulse;
  wire             m_pulse;
  wire             range;
  wire             apb_req;
  wire             apb_done;
  wire             wr_en;
  wire             unlock_now;
  wire [2:0]       events;
  wire [2:0]       clr_mask;

  // --------------------------------------------------------------------
  // Dividers
  // --------------------------------------------------------------------

  // Either top bit of the reference divide number marks sixteen or more
  assign range = ndiv[`QSPD_RANGE_LO] | ndiv[`QSPD_RANGE_HI];

  // Reference-clocked divider: rate is reference over quarter number from sixteen up
  qspd_div #(.DIV_W(DIV_W)) u_ndiv
  (
    .i_clk    (I_CLK),
    .i_rst_n  (I_RST_N),
    .i_run    (run),
    .i_tick   (I_REF_TICK),
    .i_divide (ndiv),
    .i_range  (range),
    .o_out    (n_out),
    .o_pulse  (n_pulse)
  );

  // Second divider, same logic, same range signal
  qspd_div #(.DIV_W(DIV_W)) u_mdiv
  (
    .i_clk    (I_CLK),
    .i_rst_n  (I_RST_N),
    .i_run    (run),
    .i_tick   (I_IF_TICK),
    .i_divide (mdiv),
    .i_range  (range),
    .o_out    (m_out),
    .o_pulse  (m_pulse)
  );

  // --------------------------------------------------------------------
  // Phase/frequency detector
  // --------------------------------------------------------------------

  // Leading edge sets its side; both set means clear, so only the
  // leader shows a pulse as wide as the edge difference
  always @*
  begin
    next_a = O_DETECTOR_OUT_A | (n_out & ~n_prev);
    next_b = O_DETECTOR_OUT_B | (m_out & ~m_prev);
    if (next_a && next_b)
    begin
      next_a = 1'b0;
      next_b = 1'b0;
    end
  end

  // Detector flip-flops and registered divider outputs
  always @(posedge I_CLK)
  begin
    if (!I_RST_N || !run)
    begin
      n_prev           <= 1'b0;
      m_prev           <= 1'b0;
      O_N_DIV          <= 1'b0;
      O_M_DIV          <= 1'b0;
      O_DETECTOR_OUT_A <= 1'b0;
      O_DETECTOR_OUT_B <= 1'b0;
    end
    else
    begin
      n_prev           <= n_out;
      m_prev           <= m_out;
      O_N_DIV          <= n_out;
      O_M_DIV          <= m_out;
      O_DETECTOR_OUT_A <= next_a;
      O_DETECTOR_OUT_B <= next_b;
    end
  end

  // --------------------------------------------------------------------
  // Lock detector
  // --------------------------------------------------------------------

  // Pulse longer than the window means the outputs differ too much
  assign unlock_now = (O_DETECTOR_OUT_A | O_DETECTOR_OUT_B) &
                      (width >= lock_win);

  // Pulse width counter and unlocked flag
  always @(posedge I_CLK)
  begin
    if (!I_RST_N || !run)
    begin
      width      <= {WIN_W{1'b0}};
      O_UNLOCKED <= 1'b0;
    end
    else if (O_DETECTOR_OUT_A || O_DETECTOR_OUT_B)
    begin
      if (width != {WIN_W{1'b1}})
        width <= width + {{(WIN_W-1){1'b0}}, 1'b1};
      if (unlock_now)
        O_UNLOCKED <= 1'b1;
    end
    else
    begin
      // A pulse ended, inside or past the window: locked again
      if (width != {WIN_W{1'b0}})
        O_UNLOCKED <= 1'b0;
      width <= {WIN_W{1'b0}};
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  assign apb_req  = I_PSEL & I_PENABLE;
  assign apb_done = apb_req & O_PREADY;
  assign wr_en    = apb_done & I_PWRITE & rd_ok;

  // Read decode; rd_ok also marks a mapped address
  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (I_PADDR)
      `QSPD_ADDR_CTRL:     rd_val[`QSPD_CTRL_RUN] = run;
      `QSPD_ADDR_NDIV:     rd_val[DIV_W-1:0] = ndiv;
      `QSPD_ADDR_MDIV:     rd_val[DIV_W-1:0] = mdiv;
      `QSPD_ADDR_STATUS:   rd_val[4:0] = {O_UNLOCKED, O_DETECTOR_OUT_B,
                                          O_DETECTOR_OUT_A, O_M_DIV,
                                          O_N_DIV};
      `QSPD_ADDR_IRQ_STAT: rd_val[2:0] = irq_stat;
      `QSPD_ADDR_IRQ_CLR:  rd_val = 32'h0000_0000;
      `QSPD_ADDR_IRQ_EN:   rd_val[2:0] = irq_en;
      `QSPD_ADDR_LOCK_WIN: rd_val[WIN_W-1:0] = lock_win;
      default:             rd_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY  <= apb_req & ~O_PREADY;
      O_PSLVERR <= apb_req & ~O_PREADY & ~rd_ok;
      if (apb_req && !O_PREADY && !I_PWRITE)
        O_PRDATA <= rd_val;
      else
        O_PRDATA <= 32'h0000_0000;
    end
  end

  // Writable registers
  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      run      <= `QSPD_RST_CTRL;
      ndiv     <= `QSPD_RST_DIV;
      mdiv     <= `QSPD_RST_DIV;
      irq_en   <= `QSPD_RST_IRQ;
      lock_win <= `QSPD_RST_LOCK_WIN;
    end
    else if (wr_en)
    begin
      case (I_PADDR)
        `QSPD_ADDR_CTRL:     run      <= I_PWDATA[`QSPD_CTRL_RUN];
        `QSPD_ADDR_NDIV:     ndiv     <= I_PWDATA[DIV_W-1:0];
        `QSPD_ADDR_MDIV:     mdiv     <= I_PWDATA[DIV_W-1:0];
        `QSPD_ADDR_IRQ_EN:   irq_en   <= I_PWDATA[2:0];
        `QSPD_ADDR_LOCK_WIN: lock_win <= I_PWDATA[WIN_W-1:0];
        default:             run      <= run;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  assign events   = {unlock_now & ~O_UNLOCKED, m_pulse, n_pulse};
  assign clr_mask = (wr_en && I_PADDR == `QSPD_ADDR_IRQ_CLR) ?
                    I_PWDATA[2:0] : 3'h0;

  // Sticky status: a new event wins over a clear in the same cycle
  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      irq_stat <= `QSPD_RST_IRQ;
      O_IRQ    <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~clr_mask) | events;
      O_IRQ    <= |(((irq_stat & ~clr_mask) | events) & irq_en);
    end
  end

endmodule // qspd_top

/* File: tb/qspd_chk_sva.sv */
// Port assertions for the divider pair
`timescale 1ns/10ps
module qspd_chk
(
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_REF_TICK,
  input wire logic        I_IF_TICK,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_N_DIV,
  input wire logic        O_M_DIV,
  input wire logic        O_DETECTOR_OUT_A,
  input wire logic        O_DETECTOR_OUT_B,
  input wire logic        O_UNLOCKED,
  input wire logic        O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  apb_wait_a: assert property (I_PSEL && $rose(I_PENABLE)
    |-> !O_PREADY ##1 O_PREADY) else $error("ready late or early");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside ready");
  reset_clear_a: assert property (disable iff (1'b0) !I_RST_N
    |=> !O_N_DIV && !O_M_DIV && !O_UNLOCKED && !O_IRQ && !O_PREADY)
    else $error("outputs not cleared by reset");
  n_clear_a: assert property (O_N_DIV && I_REF_TICK |-> ##2 !O_N_DIV)
    else $error("n output not cleared by next tick");
  m_clear_a: assert property (O_M_DIV && I_IF_TICK |-> ##2 !O_M_DIV)
    else $error("m output not cleared by next tick");
  det_excl_a: assert property (!(O_DETECTOR_OUT_A && O_DETECTOR_OUT_B))
    else $error("both detector outputs high");
  unlock_cause_a: assert property ($rose(O_UNLOCKED)
    |-> $past(O_DETECTOR_OUT_A) || $past(O_DETECTOR_OUT_B))
    else $error("unlock without detector pulse");

  cover property (O_PSLVERR);
  cover property ($rose(O_UNLOCKED));
  cover property ($rose(O_IRQ));
endmodule // qspd_chk

bind qspd_top qspd_chk i_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_REF_TICK(I_REF_TICK),
  .I_IF_TICK(I_IF_TICK), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_N_DIV(O_N_DIV), .O_M_DIV(O_M_DIV),
  .O_DETECTOR_OUT_A(O_DETECTOR_OUT_A), .O_DETECTOR_OUT_B(O_DETECTOR_OUT_B),
  .O_UNLOCKED(O_UNLOCKED), .O_IRQ(O_IRQ));

/* File: tb/qspd_tick_src.sv */
// Tick source standing in for the reference and IF clock inputs
`timescale 1ns/10ps
module qspd_tick_src
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Idle cycles between ticks
  input  wire logic [3:0] i_gap_ref,
  input  wire logic [3:0] i_gap_if,
  // Ticks
  output logic            o_ref_tick,
  output logic            o_if_tick
);
  logic [3:0] cr;
  logic [3:0] ci;

  // One-cycle ticks, gap 0 gives a tick every cycle
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cr         <= 4'h0;
      ci         <= 4'h0;
      o_ref_tick <= 1'b0;
      o_if_tick  <= 1'b0;
    end
    else
    begin
      cr         <= (cr >= i_gap_ref) ? 4'h0 : cr + 4'h1;
      ci         <= (ci >= i_gap_if) ? 4'h0 : ci + 4'h1;
      o_ref_tick <= (cr >= i_gap_ref);
      o_if_tick  <= (ci >= i_gap_if);
    end
  end
endmodule // qspd_tick_src

/* File: tb/tb_quarter_step_programmable_divider.sv */
// Self-checking bench for the divider pair
`timescale 1ns/10ps
`include "qspd_map.vh"
module tb_quarter_step_programmable_divider;
  logic        clk, rst_n, psel, pen, pwr, e, pn, pm, ua, sa, sb;
  logic        rdy, err, rt, it, nd, md, da, db, unl, irq;
  logic [7:0]  padr;
  logic [31:0] pwd, prd, r;
  logic [3:0]  gr, gi;
  int          mismatches, compares, cyc, cn, cm, k;
  int          qn[$], qm[$];
  int          tn[6] = '{19, 17, 18, 12, 13, 63};

  // Design and tick source
  qspd_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
    .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_REF_TICK(rt),
    .I_IF_TICK(it), .O_N_DIV(nd), .O_M_DIV(md), .O_DETECTOR_OUT_A(da),
    .O_DETECTOR_OUT_B(db), .O_UNLOCKED(unl), .O_IRQ(irq));
  qspd_tick_src i_src (.i_clk(clk), .i_rst_n(rst_n), .i_gap_ref(gr),
    .i_gap_if(gi), .o_ref_tick(rt), .o_if_tick(it));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Ticks between output rises; ceiling well above the longest run
  always @(posedge clk)
  begin
    cyc++;
    if (rt) cn++;
    if (it) cm++;
    if (nd && !pn) qn.push_back(cn);
    if (nd && !pn) cn = 0;
    if (md && !pm) qm.push_back(cm);
    if (md && !pm) cm = 0;
    pn = nd;
    pm = md;
    if (unl) ua = 1'b1;
    if (da) sa = 1'b1;
    if (db) sb = 1'b1;
    if (cyc == 90000) mismatches++;
    if (cyc == 90000) results();
  end

  task automatic check(input logic [31:0] s, x, input string n);
    compares++;
    if (s !== x)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask

  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = prd; e = err;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input string n);
    apb(1'b0, a, 32'h0);
    check(r, x, n);
  endtask

  // Four consecutive output intervals in ticks
  task automatic meas(input logic m, input int n, input logic hv);
    logic [31:0] s, v;
    s = 0;
    if (m) qm.delete(); else qn.delete();
    k = 0;
    while ((m ? qm.size() : qn.size()) < 6 && k < 9000)
    begin
      @(posedge clk);
      k++;
    end
    for (int i = 2; i < 6; i++)
    begin
      v = m ? qm[i] : qn[i];
      s += v;
      if (!hv) check(v >= n / 4 && v <= n / 4 + 1, 1, "step");
    end
    check(s, hv ? 2 * n : n, "period");
  endtask

  task automatic start(input int n, m, input logic [3:0] a, b);
    apb(1'b1, `QSPD_ADDR_CTRL, 32'h0);
    apb(1'b1, `QSPD_ADDR_NDIV, n);
    apb(1'b1, `QSPD_ADDR_MDIV, m);
    gr <= a;
    gi <= b;
    apb(1'b1, `QSPD_ADDR_CTRL, 32'h1);
  endtask

  task automatic dv(input int n, m, input logic [3:0] a, b);
    start(n, m, a, b);
    meas(1'b0, n, n < 16);
    meas(1'b1, m, n < 16);
    $display("test divide %0d %0d done", n, m);
  endtask

  task results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
    padr = 8'h00; pwd = 32'h0; gr = 4'h0; gi = 4'h0;
    ua = 1'b0; sa = 1'b0; sb = 1'b0;
    void'($urandom(86));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`QSPD_ADDR_CTRL, 32'h0, "ctrl");
    rdc(`QSPD_ADDR_NDIV, 32'h10, "ndiv");
    rdc(`QSPD_ADDR_MDIV, 32'h10, "mdiv");
    rdc(`QSPD_ADDR_LOCK_WIN, 32'h8, "win");
    rdc(`QSPD_ADDR_IRQ_STAT, 32'h0, "stat");
    rdc(`QSPD_ADDR_STATUS, 32'h0, "status");
    apb(1'b0, 8'h20, 32'h0);
    check(e, 1, "slverr");
    $display("test registers done");
    dv(16, 16, 4'h0, 4'h0);
    check(ua, 0, "locked");
    foreach (tn[i]) dv(tn[i], 16 + 5 * i, i % 3, 4'h0);
    check(sb, 1, "lead b");
    repeat (4) dv($urandom_range(63, 16), $urandom_range(63, 12),
                  $urandom_range(2), $urandom_range(2));
    apb(1'b1, `QSPD_ADDR_CTRL, 32'h0);
    apb(1'b1, `QSPD_ADDR_IRQ_CLR, 32'h7);
    apb(1'b0, `QSPD_ADDR_IRQ_STAT, 32'h0);
    check(r[1:0], 0, "clear");
    apb(1'b1, `QSPD_ADDR_IRQ_EN, 32'h1);
    check(irq, 0, "irq idle");
    start(16, 16, 4'h0, 4'h0);
    for (k = 0; irq !== 1'b1 && k < 200; k++) @(posedge clk);
    check(irq, 1, "irq on");
    apb(1'b1, `QSPD_ADDR_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    check(irq, 0, "irq mask");
    $display("test interrupt done");
    // Quarter counts 4 and 5 give lead pulses of at most four cycles,
    // so the window is narrowed to let the longer ones count as unlocked
    apb(1'b1, `QSPD_ADDR_LOCK_WIN, 32'h2);
    sa = 1'b0;
    start(16, 20, 4'h0, 4'h0);
    for (k = 0; unl !== 1'b1 && k < 4000; k++) @(posedge clk);
    check(unl, 1, "unlocked");
    check(sa, 1, "lead a");
    apb(1'b0, `QSPD_ADDR_IRQ_STAT, 32'h0);
    check(r[2], 1, "unlock event");
    $display("test lock done");
    results();
  end
endmodule // tb_quarter_step_programmable_divider
